// ==== rtl/csp_pkg.sv ====
// Package of constants and carrier types for the core status and prescaler configuration block
//
// Overview of operation
// - Add sets nibble overflow flag on carry out of bit 3, else clears.
// - Prescaler configuration register is 8 bits wide and write-only.
// - Configuration-load instruction copies the accumulator into the configuration register.
// - Any reset sets all eight configuration bits to one.
// - Direction bit 0 disables pull-up and wake-on-change for that pin.
// - Timer source select 1 overrides pin direction on timer clock pin.
// - Sleep flag set at power-up or watchdog clear, cleared by sleep.
// - Zero flag follows whether an add, subtract or logic result equals zero.
package csp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [4:0] STATUS_ADDR = 5'h03;

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_WDOG = 4;
    localparam int ST_PAGE = 5;
    localparam int ST_RSVD = 6;
    localparam int ST_WAKE = 7;

    // ************************************************************
    // Configuration field positions and reset value
    // ************************************************************
    localparam int CFG_WAKE_DIS = 7;
    localparam int CFG_PULLUP_DIS = 6;
    localparam int CFG_T0_SRC = 5;
    localparam logic [7:0] CFG_RESET = 8'hFF;
    localparam logic [7:0] ST_WRITE_MASK = 8'hA0;

    // ************************************************************
    // Operation codes for the flag update port
    // ************************************************************
    typedef enum logic [2:0] {
        CSP_OP_NONE = 3'b000,
        CSP_OP_ADD = 3'b001,
        CSP_OP_SUB = 3'b010,
        CSP_OP_RRF = 3'b011,
        CSP_OP_RLF = 3'b100,
        CSP_OP_LOGIC = 3'b101
    } csp_op_t;

    // Operands of one arithmetic or logic operation
    typedef struct packed {
        csp_op_t op;
        logic [7:0] accum;
        logic [7:0] file_val;
    } csp_alu_req_t;

    // Reset cause presented with the reset pulse
    typedef struct packed {
        logic power_up;
        logic wake_pin_change;
    } csp_reset_cause_t;

endpackage : csp_pkg

// ==== rtl/csp_core_status.sv ====
// Core status register, prescaler configuration register and pin override logic
module csp_core_status #(
    parameter int PIN_COUNT = 8,
    parameter int T0_PIN = 2
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire csp_pkg::csp_reset_cause_t reset_cause_in,
    // Operation events
    input wire csp_pkg::csp_alu_req_t alu_req_in,
    input wire logic config_load_in,
    input wire logic watchdog_clear_op_in,
    input wire logic sleep_op_in,
    input wire logic watchdog_timeout_in,
    // Status register write port
    input wire logic status_wr_in,
    input wire logic [4:0] status_addr_in,
    input wire logic [7:0] status_wdata_in,
    // Pin direction
    input wire logic [PIN_COUNT-1:0] pin_direction_reg_in,
    // Outputs
    output logic [7:0] status_out,
    output logic [7:0] alu_result_out,
    output logic [PIN_COUNT-1:0] pullup_en_out,
    output logic [PIN_COUNT-1:0] wake_en_out,
    output logic [PIN_COUNT-1:0] pin_input_out
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] status;
    logic [7:0] next_status;
    logic [7:0] reset_status;
    logic [7:0] prescaler_config;
    logic [7:0] next_prescaler_config;
    logic [7:0] alu_result;
    logic [7:0] next_alu_result;
    logic [PIN_COUNT-1:0] pullup_en;
    logic [PIN_COUNT-1:0] next_pullup_en;
    logic [PIN_COUNT-1:0] wake_en;
    logic [PIN_COUNT-1:0] next_wake_en;
    logic [PIN_COUNT-1:0] pin_input;
    logic [PIN_COUNT-1:0] next_pin_input;

    // ************************************************************
    // Status and configuration next state
    // ************************************************************
    always_comb begin
        logic [4:0] low_sum;
        logic [8:0] full_sum;
        logic [7:0] res;
        logic write_hit;
        low_sum = 5'h00;
        full_sum = 9'h000;
        res = 8'h00;
        write_hit = status_wr_in && (status_addr_in == csp_pkg::STATUS_ADDR);
        next_status = status;
        next_alu_result = alu_result;
        // Software may write only the wake flag and page bit; reserved bit 6 is held at zero
        if (write_hit) begin
            next_status = (status & ~csp_pkg::ST_WRITE_MASK) | (status_wdata_in & csp_pkg::ST_WRITE_MASK);
        end
        case (alu_req_in.op)
            csp_pkg::CSP_OP_ADD: begin
                low_sum = {1'b0, alu_req_in.file_val[3:0]} + {1'b0, alu_req_in.accum[3:0]};
                full_sum = {1'b0, alu_req_in.file_val} + {1'b0, alu_req_in.accum};
                res = full_sum[7:0];
                next_status[csp_pkg::ST_NIBBLE] = low_sum[4];
                next_status[csp_pkg::ST_CARRY] = full_sum[8];
                next_status[csp_pkg::ST_ZERO] = (res == 8'h00);
                next_alu_result = res;
            end
            csp_pkg::CSP_OP_SUB: begin
                // Carry and nibble flag read as not-borrow
                low_sum = {1'b0, alu_req_in.file_val[3:0]} + {1'b0, ~alu_req_in.accum[3:0]} + 5'h01;
                full_sum = {1'b0, alu_req_in.file_val} + {1'b0, ~alu_req_in.accum} + 9'h001;
                res = full_sum[7:0];
                next_status[csp_pkg::ST_NIBBLE] = low_sum[4];
                next_status[csp_pkg::ST_CARRY] = full_sum[8];
                next_status[csp_pkg::ST_ZERO] = (res == 8'h00);
                next_alu_result = res;
            end
            csp_pkg::CSP_OP_RRF: begin
                next_alu_result = {status[csp_pkg::ST_CARRY], alu_req_in.file_val[7:1]};
                next_status[csp_pkg::ST_CARRY] = alu_req_in.file_val[0];
            end
            csp_pkg::CSP_OP_RLF: begin
                next_alu_result = {alu_req_in.file_val[6:0], status[csp_pkg::ST_CARRY]};
                next_status[csp_pkg::ST_CARRY] = alu_req_in.file_val[7];
            end
            csp_pkg::CSP_OP_LOGIC: begin
                res = alu_req_in.accum & alu_req_in.file_val;
                next_status[csp_pkg::ST_ZERO] = (res == 8'h00);
                next_alu_result = res;
            end
            default: begin
                next_alu_result = alu_result;
            end
        endcase
        // Watchdog clear sets sleep flag; sleep clears it
        if (watchdog_clear_op_in) begin
            next_status[csp_pkg::ST_SLEEP] = 1'b1;
            next_status[csp_pkg::ST_WDOG] = 1'b1;
        end else if (sleep_op_in) begin
            next_status[csp_pkg::ST_SLEEP] = 1'b0;
            next_status[csp_pkg::ST_WDOG] = 1'b1;
        end
        // Time-out clears the watchdog flag and wins over the instructions
        if (watchdog_timeout_in) begin
            next_status[csp_pkg::ST_WDOG] = 1'b0;
        end
        next_status[csp_pkg::ST_RSVD] = 1'b0;
    end

    // ************************************************************
    // Status value taken while reset is held
    // ************************************************************
    always_comb begin
        // Arithmetic flags keep their values across a reset; the page bit keeps its value across any reset but power-up
        reset_status = status;
        // Wake flag follows the reset cause
        reset_status[csp_pkg::ST_WAKE] = reset_cause_in.wake_pin_change & ~reset_cause_in.power_up;
        reset_status[csp_pkg::ST_RSVD] = 1'b0;
        // Only a power-up gives the page and power flags fixed values
        if (reset_cause_in.power_up) begin
            reset_status[csp_pkg::ST_PAGE] = 1'b0;
            reset_status[csp_pkg::ST_WDOG] = 1'b1;
            reset_status[csp_pkg::ST_SLEEP] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            status <= reset_status;
        end else begin
            status <= next_status;
        end
    end

    // Cleared by reset so a stale result never outlives a restart
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            alu_result <= 8'h00;
        end else begin
            alu_result <= next_alu_result;
        end
    end

    // ************************************************************
    // Prescaler configuration register
    // ************************************************************
    always_comb begin
        next_prescaler_config = prescaler_config;
        if (config_load_in) begin
            next_prescaler_config = alu_req_in.accum;
        end
    end

    // Software cannot read it back; it only steers the pin overrides below
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            prescaler_config <= csp_pkg::CFG_RESET;
        end else begin
            prescaler_config <= next_prescaler_config;
        end
    end

    // ************************************************************
    // Per-pin pull-up, wake and direction overrides
    // ************************************************************
    // T0_PIN must lie below PIN_COUNT, or no pin is ever forced to input
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        always_comb begin
            // Output direction kills pull-up and wake
            next_pullup_en[i] = pin_direction_reg_in[i] & ~prescaler_config[csp_pkg::CFG_PULLUP_DIS];
            next_wake_en[i] = pin_direction_reg_in[i] & ~prescaler_config[csp_pkg::CFG_WAKE_DIS];
            // Timer source forces the clock pin to input
            if (i == T0_PIN) begin
                next_pin_input[i] = pin_direction_reg_in[i] | prescaler_config[csp_pkg::CFG_T0_SRC];
            end else begin
                next_pin_input[i] = pin_direction_reg_in[i];
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            pullup_en <= '0;
            wake_en <= '0;
            pin_input <= '1;
        end else begin
            pullup_en <= next_pullup_en;
            wake_en <= next_wake_en;
            pin_input <= next_pin_input;
        end
    end

    // ************************************************************
    // Outputs, each straight from a flip-flop
    // ************************************************************
    assign status_out = status;
    assign alu_result_out = alu_result;
    assign pullup_en_out = pullup_en;
    assign wake_en_out = wake_en;
    assign pin_input_out = pin_input;

endmodule : csp_core_status

// ==== verification/csp_core_status_chk.sv ====
// Assertion checker bound to the core status and configuration block
module csp_core_status_chk #(
    parameter int PIN_COUNT = 8,
    parameter int T0_PIN = 2
) (
    // Clock, reset and events
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire csp_pkg::csp_reset_cause_t reset_cause_in,
    input wire csp_pkg::csp_alu_req_t alu_req_in,
    input wire logic config_load_in,
    input wire logic watchdog_clear_op_in,
    input wire logic sleep_op_in,
    input wire logic watchdog_timeout_in,
    input wire logic status_wr_in,
    input wire logic [4:0] status_addr_in,
    input wire logic [7:0] status_wdata_in,
    input wire logic [PIN_COUNT-1:0] pin_direction_reg_in,
    // Observed outputs
    input wire logic [7:0] status_out,
    input wire logic [7:0] alu_result_out,
    input wire logic [PIN_COUNT-1:0] pullup_en_out,
    input wire logic [PIN_COUNT-1:0] wake_en_out,
    input wire logic [PIN_COUNT-1:0] pin_input_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    wire logic is_add = alu_req_in.op == csp_pkg::CSP_OP_ADD;
    wire logic is_sub = alu_req_in.op == csp_pkg::CSP_OP_SUB;
    wire logic is_and = alu_req_in.op == csp_pkg::CSP_OP_LOGIC;
    wire logic is_rrf = alu_req_in.op == csp_pkg::CSP_OP_RRF;
    a_rsvd_bit_zero: assert property (status_out[6] == 1'b0)
        else $error("reserved status bit set");
    a_add_sum_carry: assert property (is_add |=>
        {status_out[0], alu_result_out} == $past(alu_req_in.accum) + $past(alu_req_in.file_val))
        else $error("add result or carry wrong");
    a_add_nibble: assert property (is_add |=>
        status_out[1] == ($past(alu_req_in.accum[3:0]) + $past(alu_req_in.file_val[3:0]) > 5'h0F))
        else $error("nibble overflow wrong");
    a_zero_flag: assert property ((is_add || is_sub || is_and) |=>
        status_out[2] == (alu_result_out == 8'h00)) else $error("zero flag wrong");
    a_rotate_carry: assert property (is_rrf |=>
        status_out[0] == $past(alu_req_in.file_val[0]) && alu_result_out[7] == $past(status_out[0]))
        else $error("rotate through carry wrong");
    a_sleep_clears: assert property (sleep_op_in && !watchdog_clear_op_in |=> !status_out[3])
        else $error("sleep flag not cleared");
    a_clear_sets: assert property (watchdog_clear_op_in && !watchdog_timeout_in |=>
        status_out[4] && status_out[3]) else $error("watchdog clear flags wrong");
    a_timeout_flag: assert property (watchdog_timeout_in |=> !status_out[4])
        else $error("time-out flag not cleared");
    a_dir_override: assert property (!$past(reset_in) |->
        ((pullup_en_out | wake_en_out) & ~$past(pin_direction_reg_in)) == '0) else $error("output pin enabled");
    a_t0_override: assert property (config_load_in && alu_req_in.accum[5] ##1 !config_load_in |=>
        pin_input_out[T0_PIN]) else $error("timer pin not forced to input");
    a_reset_config: assert property ($fell(reset_in) |->
        pullup_en_out == '0 && wake_en_out == '0 && &pin_input_out) else $error("reset configuration wrong");
    cover property (is_add ##1 is_sub);
    cover property (watchdog_clear_op_in && sleep_op_in);
    cover property (config_load_in ##2 pin_input_out[T0_PIN]);
endmodule : csp_core_status_chk

bind csp_core_status csp_core_status_chk #(.PIN_COUNT(PIN_COUNT), .T0_PIN(T0_PIN)) u_chk (.*);

// ==== verification/tb_csp_core_status.sv ====
// Self-checking bench of the core status and configuration block
module tb_csp_core_status;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [7:0] st, sm, res, pu, wk, pi; logic rk;} csp_exp_t;
    localparam int T0 = 2;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic rst_v = 1'b1;
    csp_pkg::csp_reset_cause_t cause = 2'h2;
    csp_pkg::csp_reset_cause_t cause_v = 2'h2;
    csp_pkg::csp_alu_req_t req = '0;
    logic cfg_ld = 1'b0, clr = 1'b0, slp = 1'b0, wto = 1'b0, wr = 1'b0;
    logic [4:0] addr = 5'h03;
    logic [7:0] wd = 8'h00, dir = 8'hF0, wd_v = 8'h00, dir_v = 8'hF0;
    logic [7:0] st, res, pu, wk, pi;
    logic [7:0] m_st = 8'h00, m_sm = 8'h00, m_res = 8'h00, m_cfg = 8'hFF;
    logic m_rk = 1'b0;
    logic [8:0] s;
    logic [5:0] evs [6] = '{6'h08, 6'h10, 6'h04, 6'h18, 6'h14, 6'h0C};
    csp_exp_t q[$];
    csp_exp_t e;
    csp_exp_t g;
    int n_errors = 0;
    int comparisons = 0;
    csp_core_status #(.PIN_COUNT(8), .T0_PIN(T0)) u_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .reset_cause_in(cause), .alu_req_in(req), .config_load_in(cfg_ld), .watchdog_clear_op_in(clr),
        .sleep_op_in(slp), .watchdog_timeout_in(wto), .status_wr_in(wr), .status_addr_in(addr),
        .status_wdata_in(wd), .pin_direction_reg_in(dir), .status_out(st), .alu_result_out(res),
        .pullup_en_out(pu), .wake_en_out(wk), .pin_input_out(pi));
    initial forever #2 sys_clk_in = ~sys_clk_in;
    task automatic end_of_test;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m, input string what);
        comparisons++;
        if ((got & m) !== (exp & m)) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    // ************************************************************
    // Driver with reference model; ev is {load, clear, sleep, timeout, write, unmapped}
    // ************************************************************
    task automatic step(input logic [2:0] o, input logic [7:0] a, input logic [7:0] f, input logic [5:0] ev);
        @(posedge sys_clk_in);
        #1;
        reset_in = rst_v;
        cause = cause_v;
        req = '{csp_pkg::csp_op_t'(o), a, f};
        {cfg_ld, clr, slp, wto, wr} = ev[5:1];
        addr = ev[0] ? 5'h04 : 5'h03;
        wd = wd_v;
        dir = dir_v;
        if (reset_in) begin
            m_cfg = 8'hFF;
            m_res = 8'h00;
            m_st[7] = cause.wake_pin_change & ~cause.power_up;
            if (cause.power_up) begin
                m_st[5:3] = 3'h3;
                m_sm = m_sm | 8'hF8;
            end
            {e.pu, e.wk, e.pi} = {8'h00, 8'h00, 8'hFF};
        end else begin
            e.pu = dir & ~{8{m_cfg[6]}};
            e.wk = dir & ~{8{m_cfg[7]}};
            e.pi = dir | (8'(m_cfg[5]) << T0);
            s = {1'b0, m_res};
            case (o)
                3'h1: s = f + a;
                3'h2: s = f - a;
                3'h3: s = {f[0], m_st[0], f[7:1]};
                3'h4: s = {f, m_st[0]};
                3'h5: s = {1'b0, f & a};
                default: ;
            endcase
            if (o == 3'h1) m_st[1:0] = {f[3:0] + a[3:0] > 5'h0F, s[8]};
            if (o == 3'h2) m_st[1:0] = {f[3:0] >= a[3:0], ~s[8]};
            if (o == 3'h3 || o == 3'h4) m_st[0] = s[8];
            if (o == 3'h1 || o == 3'h2 || o == 3'h5) m_st[2] = s[7:0] == 8'h00;
            if (o == 3'h1) m_sm = m_sm | 8'h07;
            if (o == 3'h1) m_rk = 1'b1;
            if (o != 3'h0) m_res = s[7:0];
            if (wr && !ev[0]) m_st = (m_st & 8'h5F) | (wd & 8'hA0);
            if (clr) m_st[4:3] = 2'h3;
            else if (slp) m_st[4:3] = 2'h2;
            if (wto) m_st[4] = 1'b0;
            if (cfg_ld) m_cfg = a;
        end
        {e.st, e.sm, e.res, e.rk} = {m_st, m_sm, m_res, m_rk};
        q.push_back(e);
    endtask : step
    // ************************************************************
    // Monitor and scenarios
    // ************************************************************
    always @(posedge sys_clk_in) begin
        #0.5;
        if (q.size() > 0) begin
            g = q.pop_front();
            cmp(st, g.st, g.sm, "status");
            cmp(res, g.res, {8{g.rk}}, "result");
            cmp(pu, g.pu, 8'hFF, "pullup");
            cmp(wk, g.wk, 8'hFF, "wake");
            cmp(pi, g.pi, 8'hFF, "input");
        end
    end
    initial begin
        void'($urandom(32'hB426));
        repeat (16) step(3'h0, 8'h00, 8'h00, 6'h00);
        rst_v = 1'b0;
        step(3'h1, 8'h08, 8'h08, 6'h00);
        step(3'h1, 8'h01, 8'hFF, 6'h00);
        step(3'h2, 8'h05, 8'h05, 6'h00);
        step(3'h2, 8'h06, 8'h03, 6'h00);
        step(3'h3, 8'h00, 8'h81, 6'h00);
        step(3'h4, 8'h00, 8'h7E, 6'h00);
        step(3'h5, 8'h00, 8'hFF, 6'h20);
        repeat (2) step(3'h0, 8'h00, 8'h00, 6'h00);
        dir_v = 8'h0B;
        step(3'h0, 8'h20, 8'h00, 6'h20);
        repeat (2) step(3'h0, 8'h00, 8'h00, 6'h00);
        foreach (evs[i]) step(3'h0, 8'h00, 8'h00, evs[i]);
        wd_v = 8'hFF;
        step(3'h0, 8'h00, 8'h00, 6'h02);
        wd_v = 8'h00;
        step(3'h0, 8'h00, 8'h00, 6'h03);
        {rst_v, cause_v} = 3'h5;
        repeat (2) step(3'h0, 8'h00, 8'h00, 6'h00);
        cause_v = 2'h0;
        step(3'h0, 8'h00, 8'h00, 6'h00);
        rst_v = 1'b0;
        step(3'h0, 8'h00, 8'h00, 6'h00);
        for (int i = 0; i < 300; i++) begin
            wd_v = 8'($urandom);
            dir_v = 8'($urandom);
            step(3'($urandom_range(5)), 8'($urandom), 8'($urandom), 6'($urandom) & 6'($urandom));
        end
        for (int i = 0; i < 8 && q.size() > 0; i++) @(posedge sys_clk_in);
        if (q.size() > 0) begin
            n_errors++;
            $display("MISMATCH %0t expectations left over", $time);
        end
        end_of_test();
    end
endmodule : tb_csp_core_status
